// ==== bench/kpa_irq_regs_assertions.sv ====
`timescale 1ns/1ps
module kpa_irq_chk
	import kpa_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              wr,
	input wire logic              rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              key_word0_read,
	input wire logic              scan_pass_done,
	input wire logic              key_irq,
	input wire logic              pen_irq,
	input wire logic              audio_irq,
	input wire logic              irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Only writes and the word0 read may drop a request, since flags are sticky.
	property p_key_hi; rd && addr == OFS_KEY_STAT |=> rdata[15:3] == 13'h0000; endproperty
	a_key_hi: assert property (p_key_hi) else $error("key status upper bits set");
	property p_aud_rd; rd && addr == OFS_AUD_MASK |=> rdata == 16'h0000; endproperty
	a_aud_rd: assert property (p_aud_rd) else $error("audio mask read not zero");
	property p_pen_rd; rd && addr == OFS_PEN_MASK |=> (rdata & ~PEN_MASK_BITS) == 16'h0000; endproperty
	a_pen_rd: assert property (p_pen_rd) else $error("pen mask reserved bit set");
	property p_or; irq == (key_irq | pen_irq | audio_irq); endproperty
	a_or: assert property (p_or) else $error("irq not the unit or");
	property p_key_hold; key_irq && !wr && !key_word0_read |=> key_irq; endproperty
	a_key_hold: assert property (p_key_hold) else $error("key request dropped");
	property p_pen_hold; pen_irq && !wr |=> pen_irq; endproperty
	a_pen_hold: assert property (p_pen_hold) else $error("pen request dropped");
	property p_aud_hold; audio_irq && !wr |=> audio_irq; endproperty
	a_aud_hold: assert property (p_aud_hold) else $error("audio request dropped");
	property p_rst; $fell(reset) |-> !irq; endproperty
	a_rst: assert property (p_rst) else $error("irq high after reset");
	cover property (scan_pass_done ##1 key_irq);
	cover property (pen_irq);
	cover property (audio_irq);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind kpa_irq_regs kpa_irq_chk u_chk (.clk(clk), .reset(reset), .addr(addr), .wr(wr),
	.rd(rd), .rdata(rdata), .key_word0_read(key_word0_read), .scan_pass_done(scan_pass_done),
	.key_irq(key_irq), .pen_irq(pen_irq), .audio_irq(audio_irq), .irq(irq));

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module testbench
	import kpa_pkg::*;
;
	logic        clk, reset, wr, rd, idle, upd, rdk, done, kirq, pirq, airq, irq;
	logic [31:0] addr;
	logic [15:0] wdata, rdata;
	logic [7:0]  lines;
	logic [6:0]  pen;
	logic [9:0]  aud;
	int          failures, n_tests;
	kpa_irq_regs dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .scan_input_lines(lines), .scan_seq_idle(idle), .key_word0_update(upd),
		.key_word0_read(rdk), .scan_pass_done(done), .pen_events(pen), .audio_events(aud),
		.key_irq(kirq), .pen_irq(pirq), .audio_irq(airq), .irq(irq));
	////////////////////////////////////////////////////////////////////////////
	task t; @(posedge clk); endtask
	task w(input logic [31:0] a, input logic [15:0] d); t; wr <= 1; addr <= a; wdata <= d; t; wr <= 0; #1; endtask
	task r(input logic [31:0] a, input logic [15:0] e); t; rd <= 1; addr <= a; t; rd <= 0; #1 `CHK(rdata, e) endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// A hang is cut short here, so a stuck run still reports.
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
	initial begin
		reset = 1; wr = 0; rd = 0; addr = 0; wdata = 0; lines = 8'hff; idle = 0;
		upd = 0; rdk = 0; done = 0; pen = 0; aud = 0; failures = 0; n_tests = 0;
		repeat (20) t;
		reset <= 0;
		r(OFS_KEY_STAT, 16'h0000);
		r(OFS_PEN_MASK, 16'h0000);
		w(OFS_PEN_MASK, 16'hffff);
		r(OFS_PEN_MASK, 16'h007d);
		w(OFS_AUD_MASK, 16'h0302);
		r(OFS_AUD_MASK, 16'h0000);
		r(32'h0b0000fe, 16'h0000);
		$display("registers done");
		w(OFS_KEY_EN, 16'h0007);
		t; done <= 1; t; done <= 0; t; #1;
		`CHK(kirq, 1'b1)
		w(OFS_KEY_STAT, 16'h0000);
		r(OFS_KEY_STAT, 16'h0002);
		w(OFS_KEY_STAT, 16'h0002);
		r(OFS_KEY_STAT, 16'h0000);
		t; upd <= 1; t; upd <= 0; t; upd <= 1; t; upd <= 0;
		r(OFS_KEY_STAT, 16'h0004);
		t; rdk <= 1; t; rdk <= 0;
		r(OFS_KEY_STAT, 16'h0000);
		t; idle <= 1; lines <= 8'hfe; repeat (4) t; lines <= 8'hff; idle <= 0;
		r(OFS_KEY_STAT, 16'h0001);
		`CHK(kirq, 1'b1)
		w(OFS_KEY_EN, 16'h0000);
		`CHK(kirq, 1'b0)
		$display("keyboard done");
		w(OFS_PEN_MASK, 16'h0000);
		t; pen <= 7'h01; t; pen <= 7'h00; t; #1;
		`CHK(pirq, 1'b0)
		r(OFS_PEN_STAT, 16'h0001);
		w(OFS_PEN_MASK, 16'h0001);
		`CHK(pirq, 1'b1)
		`CHK(irq, 1'b1)
		t; aud <= 10'h3ff; t; aud <= 10'h000;
		r(OFS_AUD_STAT, 16'h0302);
		`CHK(airq, 1'b1)
		w(OFS_AUD_STAT, 16'h0302);
		`CHK(airq, 1'b0)
		$display("pen and audio done");
		t; reset <= 1; t; reset <= 0; #1;
		`CHK(irq, 1'b0)
		r(OFS_PEN_MASK, 16'h0000);
		$display("reset done");
		end_of_test;
	end
endmodule

// ==== inc/kpa_pkg.sv ====
package kpa_pkg;
	localparam int          ADDR_W        = 32;
	localparam int          DATA_W        = 16;
	localparam int          SCAN_LINES    = 8;
	localparam logic [31:0] OFS_KEY_STAT  = 32'h0b000086;
	localparam logic [31:0] OFS_PEN_MASK  = 32'h0b00008e;
	localparam logic [31:0] OFS_AUD_MASK  = 32'h0b000090;
	localparam logic [31:0] OFS_KEY_EN    = 32'h0b000092;
	localparam logic [31:0] OFS_PEN_STAT  = 32'h0b000082;
	localparam logic [31:0] OFS_AUD_STAT  = 32'h0b000084;
	localparam int          KEY_PRESS_BIT = 0;
	localparam int          KEY_DONE_BIT  = 1;
	localparam int          KEY_OVR_BIT   = 2;
	localparam logic [15:0] KEY_STAT_MASK = 16'h0007;
	localparam logic [15:0] PEN_MASK_BITS = 16'h007d;
	localparam logic [15:0] AUD_MASK_BITS = 16'h0302;
	localparam logic [15:0] RESET_VALUE   = 16'h0000;
endpackage

// ==== verilog/kpa_irq_regs.sv ====
`timescale 1ns/1ps
module kpa_irq_regs
	import kpa_pkg::*;
#(
	parameter int N_SCAN = SCAN_LINES
)(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata,
	input  wire logic [N_SCAN-1:0] scan_input_lines,
	input  wire logic              scan_seq_idle,
	input  wire logic              key_word0_update,
	input  wire logic              key_word0_read,
	input  wire logic              scan_pass_done,
	input  wire logic [6:0]        pen_events,
	input  wire logic [9:0]        audio_events,
	output logic                   key_irq,
	output logic                   pen_irq,
	output logic                   audio_irq,
	output logic                   irq
);
	if (N_SCAN < 1 || N_SCAN > 16) begin
		$error("kpa_irq_regs: bad scan line count");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	wire hit_key_stat = (addr == OFS_KEY_STAT);
	wire hit_pen_mask = (addr == OFS_PEN_MASK);
	wire hit_aud_mask = (addr == OFS_AUD_MASK);
	wire hit_key_en   = (addr == OFS_KEY_EN);
	wire hit_pen_stat = (addr == OFS_PEN_STAT);
	wire hit_aud_stat = (addr == OFS_AUD_STAT);

	wire wr_key_stat = wr & hit_key_stat;
	wire wr_pen_mask = wr & hit_pen_mask;
	wire wr_aud_mask = wr & hit_aud_mask;
	wire wr_key_en   = wr & hit_key_en;
	wire wr_pen_stat = wr & hit_pen_stat;
	wire wr_aud_stat = wr & hit_aud_stat;

	////////////////////////////////////////////////////////////////////////////////
	// Keyboard event detection.

	logic [N_SCAN-1:0] scan_sync;
	logic              word0_unread;

	kpa_scan_sync #(.N(N_SCAN)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (scan_input_lines),
		.sync_out (scan_sync)
	);

	wire any_low   = ~(&scan_sync);
	wire ev_press  = scan_seq_idle & any_low;
	wire ev_done   = scan_pass_done;
	wire ev_over   = key_word0_update & word0_unread & ~key_word0_read;

	// Tracks whether the newest key data word0 has been read by the core.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			word0_unread <= 1'b0;
		end else if (key_word0_update) begin
			word0_unread <= 1'b1;
		end else if (key_word0_read) begin
			word0_unread <= 1'b0;
		end
	end

	wire [2:0] key_set;
	assign key_set[KEY_PRESS_BIT] = ev_press;
	assign key_set[KEY_DONE_BIT]  = ev_done;
	assign key_set[KEY_OVR_BIT]   = ev_over;

	wire [2:0] key_clr_wr = wr_key_stat ? wdata[2:0] : 3'h0;
	wire [2:0] key_clr_rd = {key_word0_read, 2'b00};
	wire [2:0] key_flags;

	kpa_sticky #(.W(3), .VALID(KEY_STAT_MASK)) u_key (
		.clk     (clk),
		.reset   (reset),
		.set_evt (key_set),
		.clr     (key_clr_wr | key_clr_rd),
		.flags   (key_flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pen and audio status, held here so the masks have something to gate.

	wire [15:0] pen_flags;
	wire [15:0] aud_flags;

	kpa_sticky #(.W(16), .VALID(PEN_MASK_BITS)) u_pen (
		.clk     (clk),
		.reset   (reset),
		.set_evt ({9'h000, pen_events}),
		.clr     (wr_pen_stat ? wdata : 16'h0000),
		.flags   (pen_flags)
	);

	kpa_sticky #(.W(16), .VALID(AUD_MASK_BITS)) u_aud (
		.clk     (clk),
		.reset   (reset),
		.set_evt ({6'h00, audio_events}),
		.clr     (wr_aud_stat ? wdata : 16'h0000),
		.flags   (aud_flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Mask registers.

	logic [2:0]  key_en;
	logic [15:0] pen_mask;
	logic [15:0] aud_mask;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			key_en   <= RESET_VALUE[2:0];
			pen_mask <= RESET_VALUE;
			aud_mask <= RESET_VALUE;
		end else begin
			if (wr_key_en) key_en <= wdata[2:0];
			if (wr_pen_mask) pen_mask <= wdata & PEN_MASK_BITS;
			// Unused bits are dropped in case software ignores the zero-fill duty.
			if (wr_aud_mask) aud_mask <= wdata & AUD_MASK_BITS;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request outputs; masks gate only the forwarding.

	assign key_irq   = |(key_flags & key_en);
	assign pen_irq   = |(pen_flags & pen_mask);
	assign audio_irq = |(aud_flags & aud_mask);
	assign irq       = key_irq | pen_irq | audio_irq;

	////////////////////////////////////////////////////////////////////////////////
	// Read path. The audio mask reads as zero; software must not rely on it.

	wire [15:0] rd_mux =
		hit_key_stat ? {13'h0000, key_flags} :
		hit_pen_mask ? pen_mask :
		hit_key_en   ? {13'h0000, key_en} :
		hit_pen_stat ? pen_flags :
		hit_aud_stat ? aud_flags :
		hit_aud_mask ? 16'h0000 :
		16'h0000;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= RESET_VALUE;
		end else begin
			rdata <= rd ? rd_mux : 16'h0000;
		end
	end
endmodule

// ==== verilog/kpa_scan_sync.sv ====
`timescale 1ns/1ps
module kpa_scan_sync
	import kpa_pkg::*;
#(
	parameter int N = SCAN_LINES
)(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [N-1:0] async_in,
	output logic      [N-1:0] sync_out
);
	if (N < 1) begin
		$error("kpa_scan_sync: need at least one line");
	end

	logic [N-1:0] meta;

	// Lines idle high, so both stages reset high to avoid a false key press.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta     <= {N{1'b1}};
			sync_out <= {N{1'b1}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ==== verilog/kpa_sticky.sv ====
`timescale 1ns/1ps
module kpa_sticky
	import kpa_pkg::*;
#(
	parameter int          W     = 16,
	parameter logic [15:0] VALID = 16'hffff
)(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] set_evt,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] flags
);
	// Refused at elaboration, since the valid mask and reset value are only 16 bits wide.
	if (W < 1 || W > 16) begin
		$error("kpa_sticky: width must lie between 1 and 16");
	end

	wire [W-1:0] valid_bits = VALID[W-1:0];
	// Set outranks clear so an event landing on the clear cycle survives.
	wire [W-1:0] next_flags = ((flags & ~clr) | set_evt) & valid_bits;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flags <= RESET_VALUE[W-1:0];
		end else begin
			flags <= next_flags;
		end
	end
endmodule
